// File: include/clock_select_map.vh
// Register addresses, field positions, reset values and key for the clock select and divider block.
// Assumes a word-wide plain register port carrying 32-bit byte addresses.
`ifndef CLOCK_SELECT_MAP_VH
`define CLOCK_SELECT_MAP_VH
`define MCK_CFG_ADDR    32'h0ffffc30
`define USB_CFG_ADDR    32'h0ffffc38
`define MODEM_CFG_ADDR  32'h0ffffc3c
`define PCK0_CFG_ADDR   32'h0ffffc40
`define PCK1_CFG_ADDR   32'h0ffffc44
`define IRQ_EN_ADDR     32'h0ffffc60
`define IRQ_DIS_ADDR    32'h0ffffc64
`define IRQ_STAT_ADDR   32'h0ffffc68
`define IRQ_MASK_ADDR   32'h0ffffc6c
`define WP_MODE_ADDR    32'h0ffffce4
`define WP_KEY          24'h504d43
`define MCK_CFG_MASK    32'h00001373
`define USB_CFG_MASK    32'h00000f01
`define MODEM_CFG_MASK  32'h00001f01
`define PCK_CFG_MASK    32'h00000077
`define IRQ_BITS_MASK   32'h0007034b
`define MCK_CFG_RESET   32'h00000001
`define CFG_RESET       32'h00000000
`define MCK_RDY_BIT     3
`define PCK0_RDY_BIT    8
`endif

// File: rtl/clock_select_divider_regs.v
// Clock source selection, prescalers and dividers for master, USB host, modem and two
// programmable clocks, with write protection and clock event interrupts.
// Assumes all source clocks arrive as one-cycle enable pulses synchronous to sys_clk_i.
//
// The implementer's own choice: the strobed register port.
`include "clock_select_map.vh"

module clock_select_divider_regs (
  input  wire        sys_clk_i,
  input  wire        reset_i,
  input  wire [31:0] addr_i,
  input  wire [31:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [31:0] rdata_o,
  input  wire        slow_clk_en_i,
  input  wire        main_clk_en_i,
  input  wire        pll_a_output_en_i,
  input  wire        usb_pll_en_i,
  input  wire        crystal_ready_i,
  input  wire        pll_a_locked_i,
  input  wire        usb_pll_locked_i,
  input  wire        main_source_switch_done_i,
  input  wire        rc_osc_ready_i,
  input  wire        clock_failure_event_i,
  output reg         master_clock_en_o,
  output reg         ddr_clock_en_o,
  output reg         usb_host_clock_en_o,
  output reg         soft_modem_clock_en_o,
  output reg  [1:0]  programmable_clock_out_en_o,
  output wire        irq_o
);

  reg  [31:0] mck_cfg_q;
  reg  [31:0] usb_cfg_q;
  reg  [31:0] modem_cfg_q;
  reg  [31:0] pck_cfg_q [0:1];
  reg  [31:0] irq_en_q;
  reg  [31:0] irq_stat_q;
  reg         write_protect_enable_q;
  reg         pll_half_q;
  reg  [6:0]  mpre_cnt_q;
  reg  [1:0]  master_divider_cnt_q;
  reg  [3:0]  usb_cnt_q;
  reg  [4:0]  modem_cnt_q;
  reg         mck_rdy_q;
  reg  [31:0] mck_cfg_live_q;
  reg  [1:0]  pck_rdy_q;
  reg  [31:0] events;
  reg         mck_src;
  reg         pre_tick;
  reg  [6:0]  mpre_max;
  reg  [1:0]  master_divider_max;
  wire        wp_open;
  wire        pll_path;

  assign wp_open  = ~write_protect_enable_q;
  assign pll_path = mck_cfg_q[12] ? (pll_a_output_en_i & pll_half_q) : pll_a_output_en_i;

  function [6:0] prescaler_code_max;
    input [2:0] code;
    begin
      prescaler_code_max = (code == 3'h7) ? 7'h02 : ((7'h01 << code) - 7'h01);
    end
  endfunction

  // Register writes.
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      mck_cfg_q              <= `MCK_CFG_RESET;
      usb_cfg_q              <= `CFG_RESET;
      modem_cfg_q            <= `CFG_RESET;
      pck_cfg_q[0]           <= `CFG_RESET;
      pck_cfg_q[1]           <= `CFG_RESET;
      irq_en_q               <= `CFG_RESET;
      write_protect_enable_q <= 1'b0;
    end else if (wr_i) begin
      if (wp_open) begin
        case (addr_i)
          `MCK_CFG_ADDR:   mck_cfg_q    <= wdata_i & `MCK_CFG_MASK;
          `USB_CFG_ADDR:   usb_cfg_q    <= wdata_i & `USB_CFG_MASK;
          `MODEM_CFG_ADDR: modem_cfg_q  <= wdata_i & `MODEM_CFG_MASK;
          `PCK0_CFG_ADDR:  pck_cfg_q[0] <= wdata_i & `PCK_CFG_MASK;
          `PCK1_CFG_ADDR:  pck_cfg_q[1] <= wdata_i & `PCK_CFG_MASK;
          default:         mck_cfg_q    <= mck_cfg_q;
        endcase
      end
      if (addr_i == `IRQ_EN_ADDR)
        irq_en_q <= irq_en_q | (wdata_i & `IRQ_BITS_MASK);
      if (addr_i == `IRQ_DIS_ADDR)
        irq_en_q <= irq_en_q & ~wdata_i;
      if (addr_i == `WP_MODE_ADDR && wdata_i[31:8] == `WP_KEY)
        write_protect_enable_q <= wdata_i[0];
    end
  end

  // Master source select and prescaler; settings other than the PLL halving bit 12 are sampled only at period ends.
  always @* begin
    case (mck_cfg_live_q[1:0])
      2'h0:    mck_src = slow_clk_en_i;
      2'h1:    mck_src = main_clk_en_i;
      2'h2:    mck_src = pll_path;
      default: mck_src = usb_pll_en_i;
    endcase
    mpre_max = prescaler_code_max(mck_cfg_live_q[6:4]);
    pre_tick = mck_src && (mpre_cnt_q == mpre_max);
    case (mck_cfg_live_q[9:8])
      2'h0:    master_divider_max = 2'h0;
      2'h1:    master_divider_max = 2'h1;
      2'h2:    master_divider_max = 2'h3;
      default: master_divider_max = 2'h2;
    endcase
  end

  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      pll_half_q        <= 1'b0;
      mpre_cnt_q        <= 7'h00;
      master_divider_cnt_q        <= 2'h0;
      mck_cfg_live_q    <= `MCK_CFG_RESET;
      mck_rdy_q         <= 1'b1;
      master_clock_en_o <= 1'b0;
      ddr_clock_en_o    <= 1'b0;
    end else begin
      if (pll_a_output_en_i)
        pll_half_q <= ~pll_half_q;
      master_clock_en_o <= 1'b0;
      ddr_clock_en_o    <= 1'b0;
      if (mck_src)
        mpre_cnt_q <= (mpre_cnt_q >= mpre_max) ? 7'h00 : mpre_cnt_q + 7'h01;
      if (pre_tick) begin
        if (master_divider_cnt_q >= master_divider_max) begin
          master_divider_cnt_q        <= 2'h0;
          master_clock_en_o <= 1'b1;
          ddr_clock_en_o    <= (mck_cfg_live_q[9:8] != 2'h0);
          mck_cfg_live_q    <= mck_cfg_q;
          mck_rdy_q         <= 1'b1;
        end else begin
          master_divider_cnt_q <= master_divider_cnt_q + 2'h1;
        end
      end
      if (mck_cfg_q != mck_cfg_live_q)
        mck_rdy_q <= 1'b0;
    end
  end

  // USB host and modem dividers.
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      usb_cnt_q             <= 4'h0;
      modem_cnt_q           <= 5'h00;
      usb_host_clock_en_o   <= 1'b0;
      soft_modem_clock_en_o <= 1'b0;
    end else begin
      usb_host_clock_en_o   <= 1'b0;
      soft_modem_clock_en_o <= 1'b0;
      if (usb_cfg_q[0] ? usb_pll_en_i : pll_a_output_en_i) begin
        if (usb_cnt_q >= usb_cfg_q[11:8]) begin
          usb_cnt_q           <= 4'h0;
          usb_host_clock_en_o <= 1'b1;
        end else begin
          usb_cnt_q <= usb_cnt_q + 4'h1;
        end
      end
      if (modem_cfg_q[0] ? usb_pll_en_i : pll_a_output_en_i) begin
        if (modem_cnt_q >= modem_cfg_q[12:8]) begin
          modem_cnt_q           <= 5'h00;
          soft_modem_clock_en_o <= 1'b1;
        end else begin
          modem_cnt_q <= modem_cnt_q + 5'h01;
        end
      end
    end
  end

  // Programmable clock outputs; code 7 is treated as undivided since it is reserved.
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_pck
      reg  [6:0]  cnt_q;
      reg  [31:0] live_q;
      reg         src;
      reg  [6:0]  pmax;
      always @* begin
        case (live_q[2:0])
          3'h0:    src = slow_clk_en_i;
          3'h1:    src = main_clk_en_i;
          3'h2:    src = pll_path;
          3'h3:    src = usb_pll_en_i;
          3'h4:    src = master_clock_en_o;
          default: src = 1'b0;
        endcase
        pmax = (live_q[6:4] == 3'h7) ? 7'h00 : prescaler_code_max(live_q[6:4]);
      end
      always @(posedge sys_clk_i) begin
        if (reset_i) begin
          cnt_q                           <= 7'h00;
          live_q                          <= `CFG_RESET;
          pck_rdy_q[gi]                   <= 1'b1;
          programmable_clock_out_en_o[gi] <= 1'b0;
        end else begin
          programmable_clock_out_en_o[gi] <= 1'b0;
          if (src) begin
            if (cnt_q >= pmax) begin
              cnt_q                           <= 7'h00;
              programmable_clock_out_en_o[gi] <= 1'b1;
              live_q                          <= pck_cfg_q[gi];
              pck_rdy_q[gi]                   <= 1'b1;
            end else begin
              cnt_q <= cnt_q + 7'h01;
            end
          end
          if (pck_cfg_q[gi] != live_q)
            pck_rdy_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Status flags follow their sources; the failure event is sticky until status is read.
  always @* begin
    events     = 32'h0;
    events[0]  = crystal_ready_i;
    events[1]  = pll_a_locked_i;
    events[`MCK_RDY_BIT] = mck_rdy_q;
    events[6]  = usb_pll_locked_i;
    events[`PCK0_RDY_BIT]     = pck_rdy_q[0];
    events[`PCK0_RDY_BIT + 1] = pck_rdy_q[1];
    events[16] = main_source_switch_done_i;
    events[17] = rc_osc_ready_i;
  end

  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      irq_stat_q <= 32'h0;
    end else begin
      // A failure arriving with the clearing read still sets the flag.
      irq_stat_q[18] <= clock_failure_event_i |
                        (irq_stat_q[18] & ~(rd_i && addr_i == `IRQ_STAT_ADDR));
    end
  end

  assign irq_o = |((events | irq_stat_q) & irq_en_q);

  // Read data stands one cycle after the strobe, zero otherwise.
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      rdata_o <= 32'h0;
    end else if (rd_i) begin
      case (addr_i)
        `MCK_CFG_ADDR:   rdata_o <= mck_cfg_q;
        `USB_CFG_ADDR:   rdata_o <= usb_cfg_q;
        `MODEM_CFG_ADDR: rdata_o <= modem_cfg_q;
        `PCK0_CFG_ADDR:  rdata_o <= pck_cfg_q[0];
        `PCK1_CFG_ADDR:  rdata_o <= pck_cfg_q[1];
        `IRQ_STAT_ADDR:  rdata_o <= events | irq_stat_q;
        `IRQ_MASK_ADDR:  rdata_o <= irq_en_q;
        `WP_MODE_ADDR:   rdata_o <= {31'h0, write_protect_enable_q};
        default:         rdata_o <= 32'h0;
      endcase
    end else begin
      rdata_o <= 32'h0;
    end
  end

endmodule // clock_select_divider_regs

// File: tb/clock_select_divider_regs_asserts.sv
// Port checker for the clock select and divider block.
// Assumes it is bound to the block and that the map header is on the include path.
`include "clock_select_map.vh"
module clock_select_divider_regs_asserts (
  input wire        sys_clk_i,
  input wire        reset_i,
  input wire [31:0] addr_i,
  input wire        rd_i,
  input wire [31:0] rdata_o,
  input wire        slow_clk_en_i,
  input wire        main_clk_en_i,
  input wire        pll_a_output_en_i,
  input wire        usb_pll_en_i,
  input wire        master_clock_en_o,
  input wire        ddr_clock_en_o,
  input wire        usb_host_clock_en_o,
  input wire        soft_modem_clock_en_o,
  input wire [1:0]  programmable_clock_out_en_o,
  input wire        irq_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  wire src = slow_clk_en_i | main_clk_en_i | pll_a_output_en_i | usb_pll_en_i;
  a_ddr_with_master: assert property (ddr_clock_en_o |-> master_clock_en_o)
    else $error("ddr pulse without master pulse");
  a_master_has_src: assert property (master_clock_en_o |-> $past(src))
    else $error("master pulse without source pulse");
  a_usb_has_src: assert property (usb_host_clock_en_o |-> $past(pll_a_output_en_i | usb_pll_en_i))
    else $error("usb pulse without source pulse");
  a_modem_has_src: assert property (soft_modem_clock_en_o |-> $past(pll_a_output_en_i | usb_pll_en_i))
    else $error("modem pulse without source pulse");
  a_pck_has_src: assert property (|programmable_clock_out_en_o |-> $past(src | master_clock_en_o))
    else $error("programmable pulse without source pulse");
  a_enable_reads_zero: assert property (rd_i && addr_i == `IRQ_EN_ADDR |=> rdata_o == 32'h0)
    else $error("enable register read not zero");
  a_irq_quiet_reset: assert property ($past(reset_i) |-> !irq_o)
    else $error("interrupt high after reset");
  a_no_pulse_reset: assert property ($past(reset_i) |-> !master_clock_en_o)
    else $error("master pulse right after reset");
  a_rdata_after_read: assert property (rdata_o != 32'h0 |-> $past(rd_i))
    else $error("read data outside its cycle");
  c_ddr: cover property (ddr_clock_en_o);
  c_irq: cover property (irq_o);
  c_pck: cover property (|programmable_clock_out_en_o);
endmodule // clock_select_divider_regs_asserts

bind clock_select_divider_regs clock_select_divider_regs_asserts u_chk (
  .sys_clk_i(sys_clk_i), .reset_i(reset_i), .addr_i(addr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .slow_clk_en_i(slow_clk_en_i), .main_clk_en_i(main_clk_en_i),
  .pll_a_output_en_i(pll_a_output_en_i), .usb_pll_en_i(usb_pll_en_i),
  .master_clock_en_o(master_clock_en_o), .ddr_clock_en_o(ddr_clock_en_o),
  .usb_host_clock_en_o(usb_host_clock_en_o), .soft_modem_clock_en_o(soft_modem_clock_en_o),
  .programmable_clock_out_en_o(programmable_clock_out_en_o), .irq_o(irq_o));

// File: tb/clock_select_divider_regs_tb.sv
// Self-checking bench for the clock select and divider block.
// Assumes the bound checker; sources pulse at fixed periods so gaps are in cycles.
`include "clock_select_map.vh"
module clock_select_divider_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk_i = 0, reset_i = 1, wr_i = 0, rd_i = 0, rd_p = 0, cf = 0;
  logic        slow = 0, main = 0, plla = 0, usb_pll = 0, hv, master_clock, ddr, usb, soft_modem, irq_o;
  logic [31:0] addr_i = 0, wdata_i = 0, v, a, rdata_o, exp_q[$];
  logic [4:0]  st = 0, dv;
  logic [2:0]  prescaler_code;
  logic [1:0]  source_select, pck;
  int          cyc, error_cnt, check_count, e, d0, gap[6], last[6], cnt[6];
  int          mdv[4] = '{1, 2, 4, 3};
  clock_select_divider_regs u_dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .slow_clk_en_i(slow),
    .main_clk_en_i(main), .pll_a_output_en_i(plla), .usb_pll_en_i(usb_pll),
    .crystal_ready_i(st[0]), .pll_a_locked_i(st[1]), .usb_pll_locked_i(st[2]),
    .main_source_switch_done_i(st[3]), .rc_osc_ready_i(st[4]), .clock_failure_event_i(cf),
    .master_clock_en_o(master_clock), .ddr_clock_en_o(ddr), .usb_host_clock_en_o(usb),
    .soft_modem_clock_en_o(soft_modem), .programmable_clock_out_en_o(pck), .irq_o(irq_o));
  always #10 sys_clk_i = ~sys_clk_i;
  // Distinct source periods let a wrong source selection show up as a wrong gap.
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    slow <= cyc % 14 == 0;
    main <= cyc % 10 == 0;
    plla <= cyc % 2 == 0;
    usb_pll <= cyc % 6 == 0;
    for (int i = 0; i < 6; i++) if ({pck, soft_modem, usb, ddr, master_clock} >> i & 6'h1) begin
      gap[i] <= cyc - last[i];
      last[i] <= cyc;
      cnt[i] <= cnt[i] + 1;
    end
  end
  always @(posedge sys_clk_i) rd_p <= rd_i;
  always @(negedge sys_clk_i) if (rd_p) chk("rdata", exp_q.pop_front(), rdata_o);
  function automatic int per(input int c, input int h);
    return c == 0 ? 14 : c == 1 ? 10 : c == 2 ? 2 << h : c == 3 ? 6 : 10;
  endfunction
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    check_count++;
    if (g !== x) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic wr(input logic [31:0] ad, input logic [31:0] d);
    addr_i <= ad;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i) wr_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  task automatic rd(input logic [31:0] ad, input logic [31:0] x);
    addr_i <= ad;
    rd_i <= 1'b1;
    exp_q.push_back(x);
    @(posedge sys_clk_i) rd_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  task automatic gap_chk(input int i, input int x, input string n);
    int c0;
    c0 = cnt[i];
    for (int t = 0; t < 20000 && cnt[i] < c0 + 3; t++) @(posedge sys_clk_i);
    chk(n, x, gap[i]);
  endtask
  task automatic irq_chk(input logic x);
    repeat (2) @(posedge sys_clk_i);
    @(negedge sys_clk_i) chk("irq", {31'h0, x}, {31'h0, irq_o});
    @(posedge sys_clk_i);
  endtask
  task end_of_test;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    #1800000;
    error_cnt++;
    end_of_test();
  end
  initial begin
    void'($urandom(18930));
    repeat (6) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    rd(`MCK_CFG_ADDR, `MCK_CFG_RESET);
    rd(`USB_CFG_ADDR, `CFG_RESET);
    rd(`PCK1_CFG_ADDR, `CFG_RESET);
    rd(`IRQ_EN_ADDR, 32'h0);
    rd(32'h0ffffc34, 32'h0);
    $display("test reset values done");
    wr(`WP_MODE_ADDR, {24'h504d42, 8'h01});
    wr(`USB_CFG_ADDR, 32'h00000203);
    rd(`USB_CFG_ADDR, 32'h00000201);
    wr(`WP_MODE_ADDR, {`WP_KEY, 8'h01});
    rd(`WP_MODE_ADDR, 32'h1);
    wr(`USB_CFG_ADDR, 32'h00000001);
    rd(`USB_CFG_ADDR, 32'h00000201);
    wr(`WP_MODE_ADDR, {`WP_KEY, 8'h00});
    $display("test protection done");
    for (int i = 0; i < 4; i++) begin
      source_select = 2'($urandom_range(3));
      prescaler_code = i == 0 ? 3'h7 : 3'($urandom_range(5));
      hv = 1'($urandom_range(1));
      v = {19'h0, hv, 2'h0, 2'(i), 1'b0, prescaler_code, 2'h0, source_select};
      wr(`MCK_CFG_ADDR, v);
      rd(`MCK_CFG_ADDR, v);
      e = per(source_select, hv) * (prescaler_code == 3'h7 ? 3 : 1 << prescaler_code) * mdv[i];
      gap_chk(0, e, "master");
      d0 = cnt[1];
      gap_chk(0, e, "master");
      if (i == 0) chk("ddr_count", 0, cnt[1] - d0);
      else chk("ddr_gap", e, gap[1]);
    end
    wr(`MCK_CFG_ADDR, 32'h1);
    gap_chk(0, 10, "master");
    $display("test master clock done");
    for (int i = 0; i < 4; i++) begin
      dv = 5'($urandom_range(i % 2 ? 31 : 15));
      v = {19'h0, dv, 7'h0, 1'(i / 2)};
      a = i % 2 ? `MODEM_CFG_ADDR : `USB_CFG_ADDR;
      wr(a, v);
      rd(a, v);
      gap_chk(2 + i % 2, per(i / 2 ? 3 : 2, 0) * (dv + 1), "usb_modem");
    end
    $display("test usb and modem done");
    for (int i = 0; i < 5; i++) begin
      prescaler_code = 3'($urandom_range(6));
      v = {25'h0, prescaler_code, 1'b0, 3'(i)};
      a = i % 2 ? `PCK1_CFG_ADDR : `PCK0_CFG_ADDR;
      wr(a, v);
      rd(a, v);
      gap_chk(4 + i % 2, per(i, 0) << prescaler_code, "pck");
    end
    $display("test programmable clocks done");
    wr(`IRQ_EN_ADDR, 32'h00030043);
    wr(`IRQ_EN_ADDR, 32'h0);
    rd(`IRQ_MASK_ADDR, 32'h00030043);
    for (int k = 0; k < 5; k++) begin
      st <= 5'h1 << k;
      irq_chk(1'b1);
    end
    st <= 5'h0;
    irq_chk(1'b0);
    wr(`IRQ_EN_ADDR, 32'hffffffff);
    rd(`IRQ_MASK_ADDR, `IRQ_BITS_MASK);
    wr(`IRQ_DIS_ADDR, 32'hffffffff);
    cf <= 1'b1;
    @(posedge sys_clk_i) cf <= 1'b0;
    irq_chk(1'b0);
    wr(`IRQ_EN_ADDR, 32'h00040000);
    irq_chk(1'b1);
    rd(`IRQ_STAT_ADDR, 32'h00040308);
    irq_chk(1'b0);
    $display("test interrupts done");
    end_of_test();
  end
endmodule // clock_select_divider_regs_tb
